//--- rtl/capture_pkg.sv
package capture_pkg;

  // register byte addresses
  localparam logic [31:0] TARGET_SIZE_ADDR = 32'h4f000000;
  localparam logic [31:0] BUF1_LUMA_ADDR = 32'h4f000004;
  localparam logic [31:0] CONTROL_ADDR = 32'h4f000080;
  localparam logic [31:0] STATUS_ADDR = 32'h4f000084;

  // reset values
  localparam logic [31:0] TARGET_SIZE_RST = 32'h000c8258;
  localparam logic [31:0] BUF1_LUMA_RST = 32'hc073f000;
  localparam logic [31:0] CONTROL_RST = 32'h00000130;
  // fixed luma bases of port a buffers two to four
  localparam logic [31:0] BUF2_LUMA_BASE = 32'hc07eec80;
  localparam logic [31:0] BUF3_LUMA_BASE = 32'hc089e900;
  localparam logic [31:0] BUF4_LUMA_BASE = 32'hc094e580;

  // target size fields
  localparam int WIDTH_LSB = 10;
  localparam int WIDTH_MSB = 19;
  localparam int HEIGHT_LSB = 0;
  localparam int HEIGHT_MSB = 9;

  // control fields
  localparam int CTL_EMBEDDED = 0;
  localparam int CTL_VPOL = 1;
  localparam int CTL_HPOL = 2;
  localparam int CTL_SENSOR_RST = 3;
  localparam int CTL_A_EN = 4;
  localparam int CTL_B_EN = 5;
  localparam int CTL_PULSE = 6;
  localparam int CTL_DIV_LSB = 8;
  localparam int CTL_DIV_MSB = 15;

  // status fields
  localparam int ST_BUF_LSB = 0;
  localparam int ST_BUF_MSB = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_FIELD = 3;
  localparam int ST_BLANK = 4;
  localparam int ST_OVERFLOW = 5;
  localparam int ST_IRQ = 6;
  localparam int ST_FRAMES_LSB = 8;
  localparam int ST_FRAMES_MSB = 15;

  // longest accepted input line in pixels
  localparam logic [9:0] LINE_MAX = 10'h3f8;

  // embedded timing code bytes and fourth-word bit positions
  localparam logic [7:0] CODE_FF = 8'hff;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam int XY_ONE = 7;
  localparam int XY_F = 6;
  localparam int XY_V = 5;
  localparam int XY_H = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sample planes, also the index into per-plane arrays
  typedef enum logic [1:0] {
    PLANE_Y = 2'h0,
    PLANE_CB = 2'h1,
    PLANE_CR = 2'h2
  } plane_t;

  // timing code detector states, gray along the preamble path
  typedef enum logic [1:0] {
    DET_IDLE = 2'h0,
    DET_FF = 2'h1,
    DET_00A = 2'h3,
    DET_00B = 2'h2
  } det_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  // camera pins as sampled together
  typedef struct packed {
    logic pclk;
    logic vsync;
    logic line_reference_in;
    logic [7:0] data;
  } cam_pins_t;

  // one packed memory word leaving a port
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } dma_word_t;

endpackage : capture_pkg

//--- rtl/pin_sync.sv
module pin_sync #(
  parameter int W = 11
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q; // accepted level
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;

  // a bit changes once stages two and three agree
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        n.q[i] = r.s2[i];
      end
    end
  end

  // register the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.q;
endmodule // pin_sync

//--- rtl/port_writer.sv
module port_writer
  import capture_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic frame_start,
  input wire logic pix_valid,
  input wire capture_pkg::plane_t pix_plane,
  input wire logic [7:0] pix_byte,
  input wire logic [2:0][31:0] plane_base,
  output capture_pkg::dma_word_t word_out
);
  typedef struct packed {
    logic [2:0][31:0] acc; // partial word per plane
    logic [2:0][1:0] cnt; // bytes held per plane
    logic [2:0][29:0] off; // word offset per plane
    dma_word_t out;
  } writer_state_t;

  writer_state_t r;
  writer_state_t n;

  // pack bytes little-endian, earliest byte lowest
  always_comb begin
    n = r;
    n.out.valid = 1'b0;
    if (frame_start) begin
      // new frame restarts every plane at its base
      n.acc = '0;
      n.cnt = '0;
      n.off = '0;
    end else if (enable && pix_valid) begin
      n.acc[pix_plane][{r.cnt[pix_plane], 3'h0} +: 8] = pix_byte;
      if (r.cnt[pix_plane] == 2'h3) begin
        // fourth byte completes the word
        n.out.valid = 1'b1;
        n.out.addr = plane_base[pix_plane] + {r.off[pix_plane], 2'h0};
        n.out.data = {pix_byte, r.acc[pix_plane][23:0]};
        n.off[pix_plane] = r.off[pix_plane] + 30'h1;
        n.cnt[pix_plane] = 2'h0;
      end else begin
        n.cnt[pix_plane] = r.cnt[pix_plane] + 2'h1;
      end
    end
  end

  // register the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign word_out = r.out;
endmodule // port_writer

//--- rtl/capture_interface.sv
// Behaviour
// - accept 8-bit 4:2:2, sync pins or codes
// - input lines up to 1016 pixels
// - store as 4:2:0, chroma on even lines
// - software selects sync input polarities
// - master clock out, software camera reset
// - embedded mode finds start and end codes
// - fourth word: one, F V H, protection
// - field and blanking flags decoded
// - line flag zero start, one end
// - flags follow the ff-00-00 preamble
// - port a writes cropped converted image
// - port b unscaled, ports disable separately
// - operation clock half master clock
// - four buffers, three planes each
// - little-endian words per plane
// - interrupt at frame start, pulse option
// - target size width and height fields
// - buffer one luma start register
module capture_interface
  import capture_pkg::*;
#(
  parameter logic [31:0] PORT_B_BASE = 32'hc0000000,
  parameter logic [31:0] PORT_B_BUF_STRIDE = 32'h00200000,
  parameter logic [31:0] PORT_B_PLANE_STRIDE = 32'h00100000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire capture_pkg::axil_req_t axil_req,
  output capture_pkg::axil_rsp_t axil_rsp,
  input wire logic pixel_clock_in,
  input wire logic vsync_in,
  input wire logic line_reference_in,
  input wire logic [7:0] pixel_data_in,
  output logic sensor_master_clock_out,
  output logic sensor_reset_out,
  output logic capture_irq,
  output capture_pkg::dma_word_t port_a_word,
  output capture_pkg::dma_word_t port_b_word
);
  import capture_pkg::*;

  typedef struct packed {
    // registers
    logic [31:0] target_size;
    logic [31:0] buf1_luma;
    logic [31:0] control;
    // clock generation
    logic [7:0] div_cnt; // master clock half-period counter
    logic mclk; // master clock level
    logic op_phase; // operation clock phase
    logic sensor_rst; // camera reset level
    // capture
    logic pclk_q; // previous pixel clock level
    logic vs_q; // previous vsync pin level
    logic hr_q; // previous line reference pin level
    det_t det; // timing code detector
    logic active; // inside active video
    logic field;
    logic blank;
    logic [1:0] phase; // Cb Y Cr Y position
    logic [9:0] x; // luma pixels this line
    logic [9:0] y; // line within frame
    logic [1:0] buf_idx; // which of the four buffers is in use
    logic [7:0] frames;
    logic overflow; // line longer than the buffer
    logic irq;
    logic frame_start;
    // sample towards the ports
    logic pix_valid;
    plane_t pix_plane;
    logic [7:0] pix_byte;
    logic pix_a;
    logic pix_b;
    // bus slave
    logic aw_held;
    logic [31:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic ar_held;
    logic [31:0] araddr;
    axil_rsp_t rsp;
  } cap_state_t;

  cap_state_t r;
  cap_state_t n;
  cam_pins_t pins; // synchronised camera pins
  logic [9:0] width; // port a target width
  logic [9:0] height; // port a target height
  logic [31:0] area; // luma bytes per port a frame
  logic [31:0] a_luma; // luma base of the active buffer
  logic [31:0] b_luma;
  logic [2:0][31:0] a_base;
  logic [2:0][31:0] b_base;
  logic pe; // pixel clock rising edge
  logic vs_a; // vsync at its active level
  logic hr_a; // line reference at its active level
  logic sample; // current byte is picture data
  logic [31:0] wr_val; // register value after byte strobes
  logic st_read; // status read completes now

  // camera pins pass the three-stage filter
  pin_sync #(.W(11)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({pixel_clock_in, vsync_in, line_reference_in, pixel_data_in}),
    .q(pins)
  );

  // target size fields and plane bases of both ports
  always_comb begin
    width = r.target_size[WIDTH_MSB:WIDTH_LSB];
    height = r.target_size[HEIGHT_MSB:HEIGHT_LSB];
    area = 32'(width) * 32'(height);
    case (r.buf_idx)
      2'h0: a_luma = r.buf1_luma;
      2'h1: a_luma = BUF2_LUMA_BASE;
      2'h2: a_luma = BUF3_LUMA_BASE;
      default: a_luma = BUF4_LUMA_BASE;
    endcase
    b_luma = PORT_B_BASE + PORT_B_BUF_STRIDE * 32'(r.buf_idx);
    // separate luma, Cb and Cr regions per buffer
    a_base[PLANE_Y] = a_luma;
    a_base[PLANE_CB] = a_luma + area;
    a_base[PLANE_CR] = a_luma + area + (area >> 2);
    b_base[PLANE_Y] = b_luma;
    b_base[PLANE_CB] = b_luma + PORT_B_PLANE_STRIDE;
    b_base[PLANE_CR] = b_luma + PORT_B_PLANE_STRIDE + (PORT_B_PLANE_STRIDE >> 2);
  end

  // write data merged under the byte strobes
  always_comb begin
    wr_val = 32'h00000000;
    case (r.awaddr)
      TARGET_SIZE_ADDR: wr_val = r.target_size;
      BUF1_LUMA_ADDR: wr_val = r.buf1_luma;
      CONTROL_ADDR: wr_val = r.control;
      default: wr_val = 32'h00000000;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (r.wstrb[i]) begin
        wr_val[i*8 +: 8] = r.wdata[i*8 +: 8];
      end
    end
  end

  // next state of the whole block
  always_comb begin
    n = r;
    n.frame_start = 1'b0;
    n.pix_valid = 1'b0;
    n.rsp.awready = 1'b0;
    n.rsp.wready = 1'b0;
    n.rsp.arready = 1'b0;
    st_read = 1'b0;
    pe = pins.pclk & ~r.pclk_q;
    vs_a = pins.vsync ^ r.control[CTL_VPOL];
    hr_a = pins.line_reference_in ^ r.control[CTL_HPOL];
    sample = 1'b0;
    n.pclk_q = pins.pclk;

    // master clock divider; operation enable at half its rate
    if (r.div_cnt >= r.control[CTL_DIV_MSB:CTL_DIV_LSB]) begin
      n.div_cnt = 8'h00;
      n.mclk = ~r.mclk;
      if (r.mclk) begin
        n.op_phase = ~r.op_phase;
        // camera reset follows software on operation clock ticks
        if (r.op_phase) begin
          n.sensor_rst = r.control[CTL_SENSOR_RST];
        end
      end
    end else begin
      n.div_cnt = r.div_cnt + 8'h01;
    end

    if (pe) begin
      if (r.control[CTL_EMBEDDED]) begin
        // embedded timing codes
        case (r.det)
          DET_IDLE: begin
            if (pins.data == CODE_FF) begin
              n.det = DET_FF;
            end else begin
              sample = r.active;
            end
          end
          DET_FF: begin
            if (pins.data == CODE_00) begin
              n.det = DET_00A;
            end else if (pins.data != CODE_FF) begin
              n.det = DET_IDLE;
            end
          end
          DET_00A: begin
            n.det = (pins.data == CODE_00) ? DET_00B : DET_IDLE;
          end
          DET_00B: begin
            n.det = DET_IDLE;
            // fourth word: msb one, then F V H, low nibble protection
            if (pins.data[XY_ONE]) begin
              n.field = pins.data[XY_F];
              n.blank = pins.data[XY_V];
              if (!pins.data[XY_H]) begin
                // start of active video
                n.active = ~pins.data[XY_V];
                n.x = 10'h000;
                n.phase = 2'h0;
                if (r.blank && !pins.data[XY_V] && !pins.data[XY_F]) begin
                  n.frame_start = 1'b1; // first field leaves blanking
                end
              end else if (r.active) begin
                // end of active video closes the line
                n.active = 1'b0;
                n.y = r.y + 10'h001;
              end
            end
          end
          default: n.det = DET_IDLE;
        endcase
      end else begin
        sample = hr_a; // separate sync inputs: bytes while the line is active
      end
    end

    // sync pins are watched every bus cycle, as the pixel clock may stand still between lines
    n.vs_q = pins.vsync;
    n.hr_q = pins.line_reference_in;
    if (!r.control[CTL_EMBEDDED]) begin
      n.active = hr_a;
      n.blank = ~vs_a;
      n.det = DET_IDLE;
      // an edge is a pin change, so flipping a polarity bit starts no frame
      if (vs_a && pins.vsync != r.vs_q) begin
        n.frame_start = 1'b1;
      end
      if (hr_a && pins.line_reference_in != r.hr_q) begin
        n.x = 10'h000;
        n.phase = 2'h0;
      end
      if (!hr_a && pins.line_reference_in != r.hr_q) begin
        n.y = r.y + 10'h001;
      end
    end

    // split the 4:2:2 stream Cb Y Cr Y into planes
    if (sample) begin
      n.phase = r.phase + 2'h1;
      n.pix_byte = pins.data;
      n.pix_plane = r.phase[0] ? PLANE_Y : (r.phase[1] ? PLANE_CR : PLANE_CB);
      if (r.x >= LINE_MAX) begin
        n.overflow = 1'b1; // bytes at or beyond LINE_MAX are dropped
      end else begin
        // chroma kept on even lines only
        n.pix_valid = r.phase[0] | ~r.y[0];
        n.pix_a = r.control[CTL_A_EN] && (r.x < width) && (r.y < height);
        n.pix_b = r.control[CTL_B_EN];
        if (r.phase[0]) begin
          n.x = r.x + 10'h001;
        end
      end
    end

    // frame start: next buffer, interrupt
    if (n.frame_start) begin
      n.y = 10'h000;
      n.buf_idx = r.buf_idx + 2'h1;
      n.frames = r.frames + 8'h01;
    end

    // write address and data taken in either order
    if (axil_req.awvalid && !r.aw_held && !r.rsp.awready && !r.rsp.bvalid) begin
      n.rsp.awready = 1'b1;
      n.aw_held = 1'b1;
      n.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && !r.w_held && !r.rsp.wready && !r.rsp.bvalid) begin
      n.rsp.wready = 1'b1;
      n.w_held = 1'b1;
      n.wdata = axil_req.wdata;
      n.wstrb = axil_req.wstrb;
    end
    // both held: perform the write and respond
    if (r.aw_held && r.w_held && !r.rsp.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = RESP_OKAY;
      case (r.awaddr)
        TARGET_SIZE_ADDR: n.target_size = wr_val;
        BUF1_LUMA_ADDR: n.buf1_luma = wr_val;
        CONTROL_ADDR: n.control = wr_val;
        STATUS_ADDR: n.rsp.bresp = RESP_OKAY;
        default: n.rsp.bresp = RESP_SLVERR;
      endcase
    end else if (r.rsp.bvalid && axil_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end

    // read: address taken, data one cycle later
    if (axil_req.arvalid && !r.ar_held && !r.rsp.arready && !r.rsp.rvalid) begin
      n.rsp.arready = 1'b1;
      n.ar_held = 1'b1;
      n.araddr = axil_req.araddr;
    end
    if (r.ar_held) begin
      n.ar_held = 1'b0;
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = RESP_OKAY;
      n.rsp.rdata = 32'h00000000;
      case (r.araddr)
        TARGET_SIZE_ADDR: n.rsp.rdata = 32'h00000000; // write-only reads zero
        BUF1_LUMA_ADDR: n.rsp.rdata = r.buf1_luma;
        CONTROL_ADDR: n.rsp.rdata = r.control;
        STATUS_ADDR: begin
          st_read = 1'b1;
          n.rsp.rdata[ST_BUF_MSB:ST_BUF_LSB] = r.buf_idx;
          n.rsp.rdata[ST_ACTIVE] = r.active;
          n.rsp.rdata[ST_FIELD] = r.field;
          n.rsp.rdata[ST_BLANK] = r.blank;
          n.rsp.rdata[ST_OVERFLOW] = r.overflow;
          n.rsp.rdata[ST_IRQ] = r.irq;
          n.rsp.rdata[ST_FRAMES_MSB:ST_FRAMES_LSB] = r.frames;
        end
        default: n.rsp.rresp = RESP_SLVERR;
      endcase
    end else if (r.rsp.rvalid && axil_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end

    // status read clears sticky flags; a new event wins
    if (r.control[CTL_PULSE]) begin
      n.irq = n.frame_start; // single pulse
    end else if (n.frame_start) begin
      n.irq = 1'b1;
    end else if (st_read) begin
      n.irq = 1'b0;
    end
    if (st_read && !(sample && r.x >= LINE_MAX)) begin
      n.overflow = 1'b0;
    end
  end

  // register the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.target_size <= TARGET_SIZE_RST;
      r.buf1_luma <= BUF1_LUMA_RST;
      r.control <= CONTROL_RST;
      r.blank <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // port a: cropped, converted image into its buffers
  port_writer u_port_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(r.pix_a),
    .frame_start(r.frame_start),
    .pix_valid(r.pix_valid),
    .pix_plane(r.pix_plane),
    .pix_byte(r.pix_byte),
    .plane_base(a_base),
    .word_out(port_a_word)
  );

  // port b: converted image only
  port_writer u_port_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(r.pix_b),
    .frame_start(r.frame_start),
    .pix_valid(r.pix_valid),
    .pix_plane(r.pix_plane),
    .pix_byte(r.pix_byte),
    .plane_base(b_base),
    .word_out(port_b_word)
  );

  assign axil_rsp = r.rsp;
  assign sensor_master_clock_out = r.mclk;
  assign sensor_reset_out = r.sensor_rst;
  assign capture_irq = r.irq;
endmodule // capture_interface

//--- tb/capture_interface_chk.sv
module capture_interface_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire capture_pkg::axil_req_t axil_req,
  input wire capture_pkg::axil_rsp_t axil_rsp,
  input wire logic sensor_master_clock_out,
  input wire capture_pkg::dma_word_t port_a_word,
  input wire capture_pkg::dma_word_t port_b_word
);
  import capture_pkg::*;
  // every check runs on the bus clock and sleeps in reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // with a divider setting above zero each master clock level lasts two bus cycles at least
  a_mclk_rate: assert property (
    $rose(sensor_master_clock_out) |=> sensor_master_clock_out)
    else $error("master clock high too short");
  a_mclk_low: assert property (
    $fell(sensor_master_clock_out) |=> !sensor_master_clock_out)
    else $error("master clock low too short");
  // read data one cycle after the address is taken
  a_read_answer: assert property (
    axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
    else $error("read answer late");
  // write response one cycle after both halves are taken
  a_write_answer: assert property (
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready |=> axil_rsp.bvalid)
    else $error("write answer late");
  // address ready is a single cycle pulse
  a_aw_pulse: assert property (
    axil_rsp.awready |=> !axil_rsp.awready)
    else $error("awready held");
  // no new write address while a response waits
  a_write_order: assert property (
    axil_rsp.bvalid |-> !axil_rsp.awready)
    else $error("address taken during response");
  // only the two defined response codes appear
  a_bresp_code: assert property (
    axil_rsp.bvalid |-> axil_rsp.bresp == RESP_OKAY || axil_rsp.bresp == RESP_SLVERR)
    else $error("bad write response");
  // each port b word is announced for one cycle
  a_word_pulse: assert property (
    port_b_word.valid |=> !port_b_word.valid)
    else $error("port b word held");
  // port a words land on aligned addresses
  a_word_align: assert property (
    port_a_word.valid |-> port_a_word.addr[1:0] == 2'h0)
    else $error("port a word misaligned");
endmodule // capture_interface_chk

bind capture_interface capture_interface_chk u_capture_interface_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .axil_req(axil_req),
  .axil_rsp(axil_rsp),
  .sensor_master_clock_out(sensor_master_clock_out),
  .port_a_word(port_a_word),
  .port_b_word(port_b_word)
);

//--- tb/camera_model.sv
module camera_model (
  input wire logic aclk,
  output logic pclk,
  output logic vsync,
  output logic line_ref,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle, pixel clock still outside frames
  initial begin
    pclk = 1'b0;
    vsync = 1'b0;
    line_ref = 1'b0;
    data = 8'h5a;
  end
  // one byte: four bus cycles low, four high, above the input filter;
  // with a divider of three this is twice the operation clock
  task automatic put(input logic [7:0] b);
    data <= b;
    repeat (4) @(posedge aclk);
    pclk <= 1'b1;
    repeat (4) @(posedge aclk);
    pclk <= 1'b0;
  endtask
  // a run of bytes with the line reference at the given level
  task automatic line(input logic [7:0] q[$], input logic act);
    line_ref <= act;
    foreach (q[i]) put(q[i]);
    line_ref <= 1'b0;
    data <= ~data;
    // the line reference rests low long enough for the filter to see the gap
    repeat (8) @(posedge aclk);
  endtask
  // frame sync pulse whose active level is act
  task automatic pulse(input logic act);
    vsync <= ~act;
    repeat (8) @(posedge aclk);
    vsync <= act;
    repeat (8) @(posedge aclk);
    vsync <= ~act;
    repeat (8) @(posedge aclk);
  endtask
endmodule // camera_model

//--- tb/camera_capture_dual_dma_port_bench.sv
module camera_capture_dual_dma_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import capture_pkg::*;
  localparam logic [31:0] B_BASE = 32'hc0000000;
  localparam logic [31:0] B_STRIDE = 32'h00200000;
  localparam logic [31:0] B_PLANE = 32'h00100000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  axil_req_t req;
  axil_rsp_t rsp;
  logic pclk, vs, hr, mclk, srst, irq;
  logic [7:0] pd;
  dma_word_t wa, wb;
  logic [63:0] qa[$];
  logic [63:0] qb[$];
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] irqs = 32'h0;
  int cyc = 0;
  // 125 MHz bus clock
  always #4 aclk = ~aclk;
  capture_interface #(.PORT_B_BASE(B_BASE), .PORT_B_BUF_STRIDE(B_STRIDE), .PORT_B_PLANE_STRIDE(B_PLANE))
    u_capture_interface (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .pixel_clock_in(pclk),
    .vsync_in(vs), .line_reference_in(hr), .pixel_data_in(pd), .sensor_master_clock_out(mclk),
    .sensor_reset_out(srst), .capture_irq(irq), .port_a_word(wa), .port_b_word(wb));
  camera_model u_camera_model (.aclk(aclk), .pclk(pclk), .vsync(vs), .line_ref(hr), .data(pd));
  // log words as a bus that grants capture at once, count interrupt cycles, cut a hang short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (wa.valid === 1'b1) qa.push_back({wa.addr, wa.data});
    if (wb.valid === 1'b1) qb.push_back({wb.addr, wb.data});
    if (irq === 1'b1) irqs <= irqs + 32'h1;
    if (cyc == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // count logged words matching key under mask
  function automatic logic [31:0] hits(ref logic [63:0] q[$], input logic [63:0] key, input logic [63:0] m);
    hits = 32'h0;
    foreach (q[i]) if ((q[i] & m) === (key & m)) hits++;
  endfunction
  // write: each channel held until its ready is sampled at a rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic b;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      b = rsp.bvalid;
      r = rsp.bresp;
    end while (!b);
  endtask
  // read: address held until arready, data taken at the edge rvalid is seen
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic v;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
      v = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
    end while (!v);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(BUF1_LUMA_ADDR, d, r);
    check("luma1 reset", d, BUF1_LUMA_RST);
    rd(CONTROL_ADDR, d, r);
    check("control reset", d, CONTROL_RST);
    wr(BUF1_LUMA_ADDR, 32'h12345678, r);
    rd(BUF1_LUMA_ADDR, d, r);
    check("luma1 back", d, 32'h12345678);
    rd(TARGET_SIZE_ADDR, d, r);
    check("size read", d, 32'h0);
    rd(32'h4f000040, d, r);
    check("unmapped resp", 32'(r), 32'(RESP_SLVERR));
  endtask
  // sync pin frame, two lines of 8 pixels, port a cropped to 4x2
  task automatic t_601();
    logic [7:0] ln[$];
    logic [31:0] n;
    logic [1:0] r;
    wr(TARGET_SIZE_ADDR, 32'h00001002, r);
    wr(CONTROL_ADDR, 32'h00000370, r);
    n = irqs;
    u_camera_model.pulse(1'b1);
    check("irq cycles", irqs - n, 32'h1);
    for (int k = 0; k < 4; k++) ln = {ln, 8'h10 + 8'(k), 8'h20 + 8'(2 * k), 8'h30 + 8'(k), 8'h21 + 8'(2 * k)};
    repeat (2) u_camera_model.line(ln, 1'b1);
    repeat (8) @(posedge aclk);
    check("a luma 0", hits(qa, {BUF2_LUMA_BASE, 32'h23222120}, '1), 32'h1);
    check("a luma 1", hits(qa, {BUF2_LUMA_BASE + 32'h4, 32'h23222120}, '1), 32'h1);
    check("a cropped", hits(qa, {32'h0, 32'h27262524}, {32'h0, 32'hffffffff}), 32'h0);
    check("b luma 0", hits(qb, {B_BASE + B_STRIDE, 32'h23222120}, '1), 32'h1);
    check("b luma 1", hits(qb, {B_BASE + B_STRIDE + 32'h4, 32'h27262524}, '1), 32'h1);
    check("b cb", hits(qb, {B_BASE + B_STRIDE + B_PLANE, 32'h13121110}, '1), 32'h1);
    check("b words", 32'(qb.size()), 32'h6);
  endtask
  task automatic t_frames();
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 4; k++) begin
      u_camera_model.pulse(1'b1);
      rd(STATUS_ADDR, d, r);
      check("buffer index", 32'(d[ST_BUF_MSB:ST_BUF_LSB]), 32'((k + 2) % 4));
    end
  endtask
  // embedded codes, port a off, bytes after the end code dropped
  task automatic t_656();
    logic [31:0] d;
    logic [1:0] r;
    wr(CONTROL_ADDR, 32'h00000361, r);
    qa.delete();
    qb.delete();
    u_camera_model.line('{8'hff, 8'h00, 8'h00, 8'he3}, 1'b0);
    rd(STATUS_ADDR, d, r);
    check("field flag", 32'(d[ST_FIELD]), 32'h1);
    check("blank flag", 32'(d[ST_BLANK]), 32'h1);
    u_camera_model.line('{8'hff, 8'h00, 8'h00, 8'h80, 8'h10, 8'h20, 8'h30, 8'h21, 8'h11, 8'h22, 8'h31, 8'h23,
      8'hff, 8'h00, 8'h00, 8'h9d, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47}, 1'b0);
    repeat (8) @(posedge aclk);
    rd(STATUS_ADDR, d, r);
    check("code start", 32'(d[ST_BUF_MSB:ST_BUF_LSB]), 32'h2);
    check("field one", 32'(d[ST_FIELD]), 32'h0);
    check("coded luma", hits(qb, {B_BASE + 2 * B_STRIDE, 32'h23222120}, '1), 32'h1);
    check("after end", 32'(qb.size()), 32'h1);
    check("a disabled", 32'(qa.size()), 32'h0);
  endtask
  // camera reset and an active-low frame sync
  task automatic t_ctl();
    logic [31:0] d;
    logic [1:0] r;
    int hi;
    wr(CONTROL_ADDR, 32'h0000037a, r);
    for (int i = 0; i < 64 && srst !== 1'b1; i++) @(posedge aclk);
    check("camera reset", 32'(srst), 32'h1);
    // divider three: four bus cycles per master clock level
    while (mclk !== 1'b0) @(posedge aclk);
    while (mclk !== 1'b1) @(posedge aclk);
    hi = 0;
    while (mclk === 1'b1) begin
      @(posedge aclk);
      hi++;
    end
    check("master clock high", 32'(hi), 32'h4);
    rd(STATUS_ADDR, d, r);
    check("polarity flip", 32'(d[ST_BUF_MSB:ST_BUF_LSB]), 32'h2);
    u_camera_model.pulse(1'b0);
    rd(STATUS_ADDR, d, r);
    check("low sync start", 32'(d[ST_BUF_MSB:ST_BUF_LSB]), 32'h3);
    check("low sync idle", 32'(d[ST_BLANK]), 32'h1);
  endtask
  initial begin
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_601();
    t_frames();
    t_656();
    t_ctl();
    end_of_test();
  end
endmodule // camera_capture_dual_dma_port_bench
